// ### logic/prc_ctrl.sv
// Periodic acquisition, result readout and reset control
//
// Behaviour
// - Decode 16-bit periodic commands: high byte rate, low byte repeatability.
// - Fetch with no buffered result: nack the read header, end exchange.
// - A fetch empties the result buffer until the next measurement completes.
// - Accelerated response command starts periodic acquisition at four per second.
// - Accelerated response shares start, fetch readout and break stop handling.
// - Break returns to single shot only after the running measurement ends.
// - System reset from soft command, reset pin pulse or power-up.
// - No received command executes while a reset procedure runs.
// - Interface recovery resets serial logic only; status flags keep value.
// - Soft reset in idle resets controller and reloads calibration data.
// - Calibration data reloads before every measurement.
// - General call reset byte acts like the reset pin.
// - General call reset only acts while commands are being serviced.
// - General call reset is address byte 00 followed by byte 06.
// - Reset pin active low, must stay low at least one microsecond.
`timescale 1ns/1ps
module prc_ctrl
	import prc_pkg::*;
#(
	parameter logic [6:0]  DEV_ADDR   = 7'h40,
	parameter logic [15:0] CMD_ART    = 16'h2B00,
	parameter logic [15:0] CMD_BREAK  = 16'h3000,
	parameter logic [15:0] CMD_FETCH  = 16'hE000,
	parameter logic [15:0] CMD_SOFT   = 16'h3001,
	parameter int          PER_10     = PER_10_CYC,
	parameter int          PER_4      = PER_4_CYC,
	parameter int          PER_1      = PER_1_CYC,
	parameter int          MEAS_HIGH  = MEAS_HIGH_CYC,
	parameter int          MEAS_MED   = MEAS_MED_CYC,
	parameter int          MEAS_LOW   = MEAS_LOW_CYC,
	parameter int          RST_LEN    = RST_CYC
)
(
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_oe,
	input  wire logic        reset_pin_n,
	input  wire logic [15:0] temp_word,
	input  wire logic [7:0]  temp_crc,
	input  wire logic [15:0] hum_word,
	input  wire logic [7:0]  hum_crc,
	output logic             meas_start_q,
	output logic [1:0]       rep_q,
	output logic             cal_reload_q,
	output logic             periodic_q,
	output logic             accelerated_response_mode,
	output logic             reset_busy_q,
	output logic             reset_seen_q
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if (PER_1 < 2 || PER_1 >= 2 ** CNT_W || PER_4 < 2 || PER_10 < 2)
		$error("period counts out of range");
	if (MEAS_HIGH < 1 || MEAS_HIGH >= PER_10 || MEAS_MED < 1 || MEAS_LOW < 1)
		$error("measurement counts out of range");
	if (RST_LEN < 1 || RST_LEN >= 2 ** CNT_W)
		$error("reset length out of range");

	logic             start_p;
	logic             stop_p;
	logic             byte_v;
	logic [7:0]       byte_d;
	logic             gc;
	logic             rd_hdr;
	logic             tx_next;
	logic [7:0]       tx_byte;
	logic             pin_s1;
	logic             pin_s2;
	logic [4:0]       pin_cnt_q;
	logic             pin_rst;
	logic [1:0]       nbyte_q;
	logic [7:0]       msb_q;
	logic             cmd_ok;
	logic [15:0]      cmd;
	logic             per_cmd;
	logic [CNT_W-1:0] per_len;
	logic [CNT_W-1:0] meas_len;
	logic [1:0]       rep;
	logic             gc_rst;
	logic             soft_rst;
	logic             sys_rst;
	prc_mode_t        mode_q;
	logic [CNT_W-1:0] rst_cnt_q;
	logic [CNT_W-1:0] per_len_q;
	logic [CNT_W-1:0] per_cnt_q;
	logic [CNT_W-1:0] meas_len_q;
	logic [CNT_W-1:0] meas_cnt_q;
	logic             brk_q;
	logic             busy_q;
	logic             done_p;
	logic             buf_v_q;
	logic [47:0]      buf_q;
	logic             out_v_q;
	logic [47:0]      out_q;
	logic [2:0]       idx_q;

	prc_i2c_slave #(.DEV_ADDR(DEV_ADDR)) u_bus
	(
		.mclk    (mclk),
		.resetn  (resetn),
		.scl_i   (scl_i),
		.sda_i   (sda_i),
		.rd_ok   (out_v_q),
		.tx_byte (tx_byte),
		.sda_oe  (sda_oe),
		.start_p (start_p),
		.stop_p  (stop_p),
		.byte_v  (byte_v),
		.byte_d  (byte_d),
		.gc      (gc),
		.rd_hdr  (rd_hdr),
		.tx_next (tx_next)
	);

	// ------------------------------------------------------------
	// Reset pin filter
	// ------------------------------------------------------------
	// Short glitches on the pin must not reset the sensor
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1    <= 1'b1;
			pin_s2    <= 1'b1;
			pin_cnt_q <= 5'h00;
		end
		else
		begin
			pin_s1 <= reset_pin_n;
			pin_s2 <= pin_s1;
			if (pin_s2)
				pin_cnt_q <= 5'h00;
			else if (pin_cnt_q != 5'(PIN_LOW_CYC))
				pin_cnt_q <= pin_cnt_q + 5'h01;
		end
	end

	assign pin_rst = !pin_s2 && pin_cnt_q == 5'(PIN_LOW_CYC - 1);

	// ------------------------------------------------------------
	// Command assembly and decode
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			nbyte_q <= 2'h0;
			msb_q   <= 8'h00;
		end
		else if (start_p || stop_p)
			nbyte_q <= 2'h0;
		else if (byte_v)
		begin
			if (nbyte_q == 2'h0)
				msb_q <= byte_d;
			if (nbyte_q != 2'h3)
				nbyte_q <= nbyte_q + 2'h1;
		end
	end

	assign cmd = {msb_q, byte_d};
	assign cmd_ok = byte_v && !gc && nbyte_q == 2'h1 && mode_q != MODE_RST;
	assign gc_rst = byte_v && gc && nbyte_q == 2'h0 && byte_d == GC_RESET_BYTE
		&& mode_q != MODE_RST;
	assign soft_rst = cmd_ok && cmd == CMD_SOFT && mode_q == MODE_SINGLE && !busy_q;
	assign sys_rst = pin_rst || gc_rst || soft_rst;

	always_comb
	begin
		per_cmd  = cmd_ok;
		per_len  = CNT_W'(PER_1);
		meas_len = CNT_W'(MEAS_HIGH);
		rep      = REP_HIGH;
		case (cmd)
			{CMD_RATE_10, REP_MED_10}:
			begin
				per_len  = CNT_W'(PER_10);
				meas_len = CNT_W'(MEAS_MED);
				rep      = REP_MED;
			end
			{CMD_RATE_10, REP_LOW_10}:
			begin
				per_len  = CNT_W'(PER_10);
				meas_len = CNT_W'(MEAS_LOW);
				rep      = REP_LOW;
			end
			{CMD_RATE_4, REP_MED_4}:
			begin
				per_len  = CNT_W'(PER_4);
				meas_len = CNT_W'(MEAS_MED);
				rep      = REP_MED;
			end
			{CMD_RATE_4, REP_LOW_4}:
			begin
				per_len  = CNT_W'(PER_4);
				meas_len = CNT_W'(MEAS_LOW);
				rep      = REP_LOW;
			end
			CMD_RATE_1_HI:
			begin
				per_len = CNT_W'(PER_1);
			end
			// Accelerated response at four per second
			CMD_ART:
			begin
				per_len = CNT_W'(PER_4);
			end
			default:
			begin
				per_cmd = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Mode control
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_q       <= MODE_RST;
			rst_cnt_q    <= CNT_W'(RST_LEN - 1);
			per_len_q    <= CNT_W'(PER_1);
			per_cnt_q    <= '0;
			meas_len_q   <= CNT_W'(MEAS_HIGH);
			rep_q        <= REP_HIGH;
			brk_q        <= 1'b0;
			meas_start_q <= 1'b0;
			cal_reload_q <= 1'b0;
			accelerated_response_mode <= 1'b0;
		end
		else
		begin
			meas_start_q <= 1'b0;
			cal_reload_q <= 1'b0;
			if (sys_rst)
			begin
				mode_q    <= MODE_RST;
				rst_cnt_q <= CNT_W'(RST_LEN - 1);
				brk_q     <= 1'b0;
				accelerated_response_mode <= 1'b0;
			end
			else if (mode_q == MODE_RST)
			begin
				if (rst_cnt_q == '0)
				begin
					mode_q       <= MODE_SINGLE;
					cal_reload_q <= 1'b1;
				end
				else
					rst_cnt_q <= rst_cnt_q - 1'b1;
			end
			// Same start path for every periodic command
			else if (per_cmd)
			begin
				mode_q     <= MODE_PERIODIC;
				per_len_q  <= per_len;
				meas_len_q <= meas_len;
				rep_q      <= rep;
				per_cnt_q  <= '0;
				brk_q      <= 1'b0;
				accelerated_response_mode <= cmd == CMD_ART;
			end
			else if (mode_q == MODE_PERIODIC)
			begin
				if (cmd_ok && cmd == CMD_BREAK)
					brk_q <= 1'b1;
				if (brk_q && !busy_q && !meas_start_q)
				begin
					mode_q <= MODE_SINGLE;
					brk_q  <= 1'b0;
					accelerated_response_mode <= 1'b0;
				end
				else if (!brk_q && per_cnt_q == '0)
				begin
					meas_start_q <= 1'b1;
					cal_reload_q <= 1'b1;
					per_cnt_q    <= per_len_q - 1'b1;
				end
				else if (per_cnt_q != '0)
					per_cnt_q <= per_cnt_q - 1'b1;
			end
		end
	end

	// Straight from the one-hot mode flop
	assign periodic_q   = mode_q[2];
	assign reset_busy_q = mode_q[0];

	// ------------------------------------------------------------
	// Measurement timer
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy_q     <= 1'b0;
			meas_cnt_q <= '0;
			done_p     <= 1'b0;
		end
		else
		begin
			done_p <= 1'b0;
			if (sys_rst)
				busy_q <= 1'b0;
			else if (meas_start_q)
			begin
				busy_q     <= 1'b1;
				meas_cnt_q <= meas_len_q - 1'b1;
			end
			else if (busy_q && meas_cnt_q == '0)
			begin
				busy_q <= 1'b0;
				done_p <= 1'b1;
			end
			else if (busy_q)
				meas_cnt_q <= meas_cnt_q - 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Result buffer and readout
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			buf_v_q <= 1'b0;
			buf_q   <= '0;
			out_v_q <= 1'b0;
			out_q   <= '0;
			idx_q   <= 3'h0;
		end
		else
		begin
			// Survives the stop after a fetch, so the host may read later
			if (rd_hdr || sys_rst)
				out_v_q <= 1'b0;
			if (cmd_ok && cmd == CMD_FETCH)
			begin
				out_q   <= buf_q;
				out_v_q <= buf_v_q;
				buf_v_q <= 1'b0;
			end
			// New result wins over a same-cycle fetch clear
			if (sys_rst)
				buf_v_q <= 1'b0;
			else if (done_p)
			begin
				buf_q   <= {temp_word, temp_crc, hum_word, hum_crc};
				buf_v_q <= 1'b1;
			end
			if (start_p || rd_hdr)
				idx_q <= 3'h0;
			else if (tx_next && idx_q != 3'h6)
				idx_q <= idx_q + 3'h1;
		end
	end

	always_comb
	begin
		case (idx_q)
			3'h0:    tx_byte = out_q[47:40];
			3'h1:    tx_byte = out_q[39:32];
			3'h2:    tx_byte = out_q[31:24];
			3'h3:    tx_byte = out_q[23:16];
			3'h4:    tx_byte = out_q[15:8];
			3'h5:    tx_byte = out_q[7:0];
			default: tx_byte = 8'hFF;
		endcase
	end

	// ------------------------------------------------------------
	// Reset detected flag
	// ------------------------------------------------------------
	// Untouched by interface recovery
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			reset_seen_q <= 1'b1;
		else if (sys_rst)
			reset_seen_q <= 1'b1;
	end

endmodule : prc_ctrl

// ### inc/prc_pkg.sv
// Shared constants and types of the periodic readout and reset controller
package prc_pkg;

	// ------------------------------------------------------------
	// Clock
	// ------------------------------------------------------------
	localparam int CLK_HZ  = 20_000_000;
	localparam int CLK_KHZ = CLK_HZ / 1000;
	localparam int CLK_MHZ = CLK_HZ / 1_000_000;

	// ------------------------------------------------------------
	// Command codes
	// ------------------------------------------------------------
	localparam logic [7:0]  CMD_RATE_10   = 8'h27;
	localparam logic [7:0]  REP_MED_10    = 8'h21;
	localparam logic [7:0]  REP_LOW_10    = 8'h2A;
	localparam logic [7:0]  CMD_RATE_4    = 8'h23;
	localparam logic [7:0]  REP_MED_4     = 8'h22;
	localparam logic [7:0]  REP_LOW_4     = 8'h29;
	localparam logic [15:0] CMD_RATE_1_HI = 16'h2130;
	localparam logic [7:0]  GC_ADDR_BYTE  = 8'h00;
	localparam logic [7:0]  GC_RESET_BYTE = 8'h06;

	// ------------------------------------------------------------
	// Repeatability codes
	// ------------------------------------------------------------
	localparam logic [1:0] REP_LOW  = 2'h0;
	localparam logic [1:0] REP_MED  = 2'h1;
	localparam logic [1:0] REP_HIGH = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int PER_10_MS      = 100;
	localparam int PER_4_MS       = 250;
	localparam int PER_1_MS       = 1000;
	localparam int MEAS_HIGH_US   = 15000;
	localparam int MEAS_MED_US    = 6000;
	localparam int MEAS_LOW_US    = 4000;
	localparam int RST_US         = 1000;
	localparam int PIN_LOW_NS     = 1000;
	localparam int PER_10_CYC     = PER_10_MS * CLK_KHZ;
	localparam int PER_4_CYC      = PER_4_MS * CLK_KHZ;
	localparam int PER_1_CYC      = PER_1_MS * CLK_KHZ;
	localparam int MEAS_HIGH_CYC  = MEAS_HIGH_US * CLK_MHZ;
	localparam int MEAS_MED_CYC   = MEAS_MED_US * CLK_MHZ;
	localparam int MEAS_LOW_CYC   = MEAS_LOW_US * CLK_MHZ;
	localparam int RST_CYC        = RST_US * CLK_MHZ;
	localparam int PIN_LOW_CYC    = (PIN_LOW_NS * CLK_MHZ + 999) / 1000;
	localparam int RECOVER_CLKS   = 9;
	localparam int CNT_W          = 26;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MODE_RST      = 3'b001,
		MODE_SINGLE   = 3'b010,
		MODE_PERIODIC = 3'b100
	} prc_mode_t;

	typedef enum logic [3:0]
	{
		BUS_IDLE = 4'b0001,
		BUS_RX   = 4'b0010,
		BUS_TX   = 4'b0100,
		BUS_SKIP = 4'b1000
	} prc_bus_t;

endpackage : prc_pkg

// ### logic/prc_i2c_slave.sv
// Byte level serial slave with interface recovery
`timescale 1ns/1ps
module prc_i2c_slave
	import prc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h40
)
(
	input  wire logic       mclk,
	input  wire logic       resetn,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	input  wire logic       rd_ok,
	input  wire logic [7:0] tx_byte,
	output logic            sda_oe,
	output logic            start_p,
	output logic            stop_p,
	output logic            byte_v,
	output logic [7:0]      byte_d,
	output logic            gc,
	output logic            rd_hdr,
	output logic            tx_next
);

	logic [2:0] scl_s;
	logic [2:0] sda_s;
	logic [3:0] rec_q;
	logic [3:0] cnt_q;
	logic [7:0] sh_q;
	logic       ackph_q;
	logic       ack_q;
	logic       rw_q;
	logic       first_q;
	prc_bus_t   st_q;
	logic       scl_rise;
	logic       scl_fall;
	logic       start_c;
	logic       stop_c;
	logic       recover;
	logic [7:0] rx_b;

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			scl_s <= 3'h7;
			sda_s <= 3'h7;
		end
		else
		begin
			scl_s <= {scl_s[1:0], scl_i};
			sda_s <= {sda_s[1:0], sda_i};
		end
	end

	assign scl_rise = scl_s[1] & ~scl_s[2];
	assign scl_fall = ~scl_s[1] & scl_s[2];
	assign start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
	assign stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];
	assign rx_b     = {sh_q[6:0], sda_s[1]};

	// ------------------------------------------------------------
	// Recovery counter
	// ------------------------------------------------------------
	// Interface only recovery
	assign recover = scl_rise & sda_s[1] & (rec_q == 4'(RECOVER_CLKS - 1));

	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			rec_q <= 4'h0;
		else if (!sda_s[1])
			rec_q <= 4'h0;
		else if (scl_rise && rec_q != 4'(RECOVER_CLKS))
			rec_q <= rec_q + 4'h1;
	end

	// ------------------------------------------------------------
	// Bit and byte engine
	// ------------------------------------------------------------
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q    <= BUS_IDLE;
			cnt_q   <= 4'h0;
			sh_q    <= 8'h00;
			ackph_q <= 1'b0;
			ack_q   <= 1'b0;
			rw_q    <= 1'b0;
			first_q <= 1'b0;
			sda_oe  <= 1'b0;
			start_p <= 1'b0;
			stop_p  <= 1'b0;
			byte_v  <= 1'b0;
			byte_d  <= 8'h00;
			gc      <= 1'b0;
			rd_hdr  <= 1'b0;
			tx_next <= 1'b0;
		end
		else
		begin
			start_p <= 1'b0;
			stop_p  <= 1'b0;
			byte_v  <= 1'b0;
			rd_hdr  <= 1'b0;
			tx_next <= 1'b0;
			if (start_c)
			begin
				st_q    <= BUS_RX;
				first_q <= 1'b1;
				cnt_q   <= 4'h0;
				ackph_q <= 1'b0;
				sda_oe  <= 1'b0;
				gc      <= 1'b0;
				start_p <= 1'b1;
			end
			else if (stop_c || recover)
			begin
				st_q    <= BUS_IDLE;
				ackph_q <= 1'b0;
				sda_oe  <= 1'b0;
				stop_p  <= stop_c;
			end
			else
			begin
				case (st_q)
					BUS_RX:
					begin
						if (scl_rise && !ackph_q)
						begin
							sh_q  <= rx_b;
							cnt_q <= cnt_q + 4'h1;
							if (cnt_q == 4'h7)
							begin
								byte_v <= !first_q;
								byte_d <= rx_b;
								if (first_q)
								begin
									ack_q <= (rx_b[7:1] == DEV_ADDR && (!rx_b[0] || rd_ok))
										|| rx_b == GC_ADDR_BYTE;
									rw_q  <= rx_b[0];
									gc    <= rx_b == GC_ADDR_BYTE;
								end
								else
									ack_q <= 1'b1;
							end
						end
						if (scl_fall && cnt_q == 4'h8 && !ackph_q)
						begin
							ackph_q <= 1'b1;
							sda_oe  <= ack_q;
						end
						else if (scl_fall && ackph_q)
						begin
							ackph_q <= 1'b0;
							sda_oe  <= 1'b0;
							cnt_q   <= 4'h0;
							first_q <= 1'b0;
							if (!ack_q)
								st_q <= BUS_SKIP;
							else if (first_q && rw_q)
							begin
								st_q   <= BUS_TX;
								sh_q   <= tx_byte;
								sda_oe <= ~tx_byte[7];
								rd_hdr <= 1'b1;
							end
						end
					end
					BUS_TX:
					begin
						if (scl_rise && !ackph_q)
						begin
							sh_q  <= {sh_q[6:0], 1'b0};
							cnt_q <= cnt_q + 4'h1;
						end
						else if (scl_rise && ackph_q)
						begin
							if (sda_s[1])
								st_q <= BUS_SKIP;
							else
								tx_next <= 1'b1;
						end
						if (scl_fall && !ackph_q)
						begin
							if (cnt_q == 4'h8)
							begin
								ackph_q <= 1'b1;
								sda_oe  <= 1'b0;
							end
							else
								sda_oe <= ~sh_q[7];
						end
						else if (scl_fall && ackph_q)
						begin
							ackph_q <= 1'b0;
							cnt_q   <= 4'h0;
							sh_q    <= tx_byte;
							sda_oe  <= ~tx_byte[7];
						end
					end
					BUS_IDLE, BUS_SKIP:
					begin
						sda_oe <= 1'b0;
					end
					default:
					begin
						st_q <= BUS_IDLE;
					end
				endcase
			end
		end
	end

endmodule : prc_i2c_slave

// ### verification/prc_host.sv
// Host model for the serial bus and the reset pin
`timescale 1ns/1ps
module prc_host
(
	input  wire logic mclk,
	input  wire logic sda,
	output logic      scl,
	output logic      pull,
	output logic      pin_n
);
	initial
	begin
		scl = 1'h1;
		pull = 1'h0;
		pin_n = 1'h1;
	end
	// Eight cycle phases, twice what the slave needs
	task automatic hp();
		repeat (8) @(negedge mclk);
	endtask : hp
	task automatic start();
		pull = 1'h0;
		hp();
		scl = 1'h1;
		hp();
		pull = 1'h1;
		hp();
		scl = 1'h0;
	endtask : start
	task automatic stop();
		repeat (2) @(negedge mclk);
		pull = 1'h1;
		hp();
		scl = 1'h1;
		hp();
		pull = 1'h0;
		hp();
	endtask : stop
	// Data moves only while the clock is low
	task automatic bit_io(input logic b, output logic r);
		repeat (2) @(negedge mclk);
		pull = !b;
		hp();
		scl = 1'h1;
		hp();
		r = sda;
		scl = 1'h0;
	endtask : bit_io
	task automatic bx(input logic [7:0] d, input logic n9, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(n9, a);
	endtask : bx
	// Header 00 then 06 for general call
	task automatic cmd(input logic [7:0] hd, input logic [15:0] c, output logic ok);
		logic [7:0] q;
		logic [2:0] a;
		start();
		bx(hd, 1'h1, q, a[0]);
		bx(c[15:8], 1'h1, q, a[1]);
		bx(c[7:0], 1'h1, q, a[2]);
		stop();
		ok = (a === 3'h0);
	endtask : cmd
	task automatic rd(output logic ok, output logic [47:0] v);
		logic [7:0] q;
		logic a;
		v = 48'h0;
		start();
		bx(8'h81, 1'h1, q, a);
		ok = !a;
		for (int i = 5; i >= 0 && ok; i--)
		begin
			bx(8'hFF, i == 0, q, a);
			v[i * 8 +: 8] = q;
		end
		stop();
	endtask : rd
	// Read abandoned, then clocks with data released
	// Twenty clocks cover a slave byte, its ack and nine more rises
	task automatic recover();
		logic [7:0] q;
		logic a;
		start();
		bx(8'h81, 1'h1, q, a);
		pull = 1'h0;
		repeat (20)
		begin
			scl = 1'h0;
			hp();
			scl = 1'h1;
			hp();
		end
	endtask : recover
	task automatic pin();
		pin_n = 1'h0;
		repeat (30) @(negedge mclk);
		pin_n = 1'h1;
	endtask : pin
endmodule : prc_host

// ### verification/prc_ctrl_sva.sv
// Port assertions of the controller
`timescale 1ns/1ps
module prc_ctrl_sva
	import prc_pkg::*;
(
	input wire logic       mclk,
	input wire logic       resetn,
	input wire logic       reset_pin_n,
	input wire logic       meas_start_q,
	input wire logic [1:0] rep_q,
	input wire logic       cal_reload_q,
	input wire logic       periodic_q,
	input wire logic       accelerated_response_mode,
	input wire logic       reset_busy_q,
	input wire logic       reset_seen_q
);
	logic [5:0] low_q;
	// Saturates so a held pin fires the check once
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
			low_q <= 6'h00;
		else if (reset_pin_n)
			low_q <= 6'h00;
		else if (low_q != 6'h28)
			low_q <= low_q + 6'h01;
	end
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!resetn);
	meas_cal_a: assert property (meas_start_q |-> cal_reload_q)
		else $error("start without reload");
	busy_quiet_a: assert property (reset_busy_q && $past(reset_busy_q)
		|-> !meas_start_q && !periodic_q) else $error("activity in reset");
	power_up_a: assert property ($rose(resetn) |-> reset_busy_q)
		else $error("no reset after power-up");
	seen_set_a: assert property (reset_busy_q |-> reset_seen_q)
		else $error("reset flag clear");
	pin_reset_a: assert property (low_q == 6'h14 |-> ##[0:8] reset_busy_q)
		else $error("pin reset missing");
	art_start_a: assert property ($rose(accelerated_response_mode)
		|-> periodic_q && rep_q == REP_HIGH) else $error("bad fast start");
	meas_pulse_a: assert property (meas_start_q |=> !meas_start_q)
		else $error("start too long");
	reload_end_a: assert property ($fell(reset_busy_q)
		|-> ##[0:1] (cal_reload_q || $past(cal_reload_q))) else $error("no reload");
endmodule : prc_ctrl_sva
bind prc_ctrl prc_ctrl_sva u_sva (.mclk, .resetn, .reset_pin_n, .meas_start_q, .rep_q,
	.cal_reload_q, .periodic_q, .accelerated_response_mode, .reset_busy_q, .reset_seen_q);

// ### verification/test_prc_ctrl.sv
// Self-checking bench of the controller
`timescale 1ns/1ps
module test_prc_ctrl;
	localparam logic [15:0] C_ACC = 16'h2B00;
	localparam logic [15:0] C_BRK = 16'h3000;
	localparam logic [15:0] C_FET = 16'hE000;
	localparam logic [15:0] C_SFT = 16'h3001;
	localparam logic [15:0] C_HI  = 16'h2130;
	localparam logic [47:0] RES   = 48'hA1B23CD4E56F;
	logic        mclk = 1'h0;
	logic        resetn = 1'h0;
	logic        scl;
	logic        pull;
	logic        pin_n;
	logic        sda;
	logic        sda_oe;
	logic        meas_start_q;
	logic [1:0]  rep_q;
	logic        cal_reload_q;
	logic        periodic_q;
	logic        acc_mode;
	logic        reset_busy_q;
	logic        reset_seen_q;
	logic [2:0]  flags;
	logic        ok;
	logic [47:0] v;
	logic [47:0] res = RES;
	int          n_mismatch = 0;
	int          n_compared = 0;
	always #25 mclk = ~mclk;
	// Open drain line with pull-up
	assign sda = !(pull | sda_oe);
	assign flags = {reset_busy_q, periodic_q, meas_start_q};
	prc_ctrl #(.PER_10(400), .PER_4(200), .PER_1(100), .MEAS_HIGH(30), .MEAS_MED(20),
		.MEAS_LOW(10), .RST_LEN(2000)) u_prc_ctrl (.mclk, .resetn, .scl_i(scl), .sda_i(sda),
		.sda_oe, .reset_pin_n(pin_n), .temp_word(res[47:32]), .temp_crc(res[31:24]),
		.hum_word(res[23:8]), .hum_crc(res[7:0]), .meas_start_q, .rep_q, .cal_reload_q,
		.periodic_q, .accelerated_response_mode(acc_mode), .reset_busy_q, .reset_seen_q);
	prc_host h (.mclk, .sda, .scl, .pull, .pin_n);
	task automatic chk(input logic [47:0] g, input logic [47:0] e);
		n_compared++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h, want %h", $time, g, e);
		end
	endtask : chk
	task automatic summarize();
		$display("compared %0d, mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic wt(input int k, input logic e);
		int i;
		for (i = 0; i < 5000 && flags[k] !== e; i++)
			@(negedge mclk);
		if (flags[k] !== e)
		begin
			n_mismatch++;
			$display("unexpected at %0t: %h, want %h", $time, flags[k], e);
			summarize();
		end
	endtask : wt
	task automatic send(input logic [15:0] c);
		h.cmd(8'h80, c, ok);
		chk(ok, 1'h1);
	endtask : send
	// ----
	// Scenarios
	// ----
	task automatic t_power();
		@(negedge mclk);
		chk(reset_busy_q, 1'h1);
		chk(reset_seen_q, 1'h1);
		wt(2, 1'h0);
		send(C_FET);
		h.rd(ok, v);
		chk(ok, 1'h0);
		$display("power-up done");
	endtask : t_power
	task automatic t_codes();
		logic [15:0] c [6] = '{16'h2721, 16'h272A, 16'h2322, 16'h2329, C_HI, C_ACC};
		logic [1:0]  r [6] = '{2'h1, 2'h0, 2'h1, 2'h0, 2'h2, 2'h2};
		for (int i = 0; i < 6; i++)
		begin
			send(c[i]);
			chk(rep_q, r[i]);
			chk(periodic_q, 1'h1);
			chk(acc_mode, c[i] == C_ACC);
			send(C_BRK);
			wt(1, 1'h0);
		end
		$display("codes done");
	endtask : t_codes
	// Inputs at the measurement start differ from the result that must be read back
	task automatic t_fetch();
		res = ~RES;
		send(C_HI);
		wt(0, 1'h1);
		res = RES;
		send(C_BRK);
		wt(1, 1'h0);
		send(C_FET);
		h.rd(ok, v);
		chk(ok, 1'h1);
		chk(v, RES);
		send(C_FET);
		h.rd(ok, v);
		chk(ok, 1'h0);
		$display("fetch done");
	endtask : t_fetch
	task automatic t_art();
		int n;
		send(C_ACC);
		wt(0, 1'h1);
		n = 0;
		do
		begin
			@(negedge mclk);
			n++;
		end
		while (meas_start_q !== 1'h1 && n < 500);
		chk(48'(n), 48'hC8);
		send(C_BRK);
		wt(1, 1'h0);
		$display("fast mode done");
	endtask : t_art
	task automatic t_rst(input int k);
		if (k == 2)
			send(C_HI);
		case (k)
			0: send(C_SFT);
			1: h.cmd(8'h00, 16'h06FF, ok);
			default: h.pin();
		endcase
		wt(2, 1'h1);
		send(C_HI);
		wt(2, 1'h0);
		chk(periodic_q, 1'h0);
		chk(reset_seen_q, 1'h1);
		$display("reset %0d done", k);
	endtask : t_rst
	// Slave left transmitting when the host gives up the read
	task automatic t_rec();
		send(C_HI);
		send(C_FET);
		h.recover();
		chk(sda_oe, 1'h0);
		chk(periodic_q, 1'h1);
		chk(reset_busy_q, 1'h0);
		send(C_BRK);
		wt(1, 1'h0);
		$display("recovery done");
	endtask : t_rec
	initial
	begin
		repeat (8) @(negedge mclk);
		resetn = 1'h1;
		t_power();
		t_codes();
		t_fetch();
		t_art();
		for (int k = 0; k < 3; k++)
			t_rst(k);
		t_rec();
		summarize();
	end
endmodule : test_prc_ctrl
